// File: bfc_pkg.sv
// Shared constants and types for the buffer flow control block.
package bfc_pkg;

  localparam int          NPORT        = 16;
  localparam int          PW           = 4;
  localparam int          CW           = 16;

  // Register byte offsets on the APB bus.
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_THRESH   = 8'h04;
  localparam logic [7:0]  OFF_SPEED    = 8'h08;
  localparam logic [7:0]  OFF_DUPLEX   = 8'h0c;
  localparam logic [7:0]  OFF_BP_EN    = 8'h10;
  localparam logic [7:0]  OFF_BUF_BLK  = 8'h14;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_MAX_WAIT = 8'h1c;
  localparam logic [7:0]  OFF_PAUSE    = 8'h20;

  // Field positions.
  localparam int          CTRL_FC_EN   = 0;
  localparam int          THR_LO_POS   = 0;
  localparam int          THR_HI_POS   = 16;
  localparam int          STAT_CONG    = 16;
  localparam int          STAT_PERM    = 17;

  // Values after reset.
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_THRESH   = 32'h0000_0000;
  localparam logic [15:0] RST_SPEED    = 16'hffff;
  localparam logic [15:0] RST_DUPLEX   = 16'hffff;
  localparam logic [15:0] RST_BP_EN    = 16'h0000;
  localparam logic [15:0] RST_BUF_BLK  = 16'h0000;

  // Slot time arithmetic: one buffer block drains in this many slots.
  localparam int          BLOCK_BYTES  = 1536;
  localparam int          SLOT_BITS    = 512;
  localparam int          SLOTS_PER_BLK = BLOCK_BYTES * 8 / SLOT_BITS;
  localparam int          SPEED_RATIO  = 10;

  // MAC control frame fields for a pause request.
  localparam logic [15:0] CTL_ETHTYPE  = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [15:0] PAUSE_MAX    = 16'hffff;
  localparam logic [15:0] PAUSE_ZERO   = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_CONG   = 3'b010,
    ST_RESUME = 3'b100
  } bfc_state_t;

endpackage

// File: bfc_flow_ctrl.sv
// Switch-wide buffer flow control with APB configuration registers.
`timescale 1ns/1ps
module bfc_flow_ctrl
  import bfc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // Buffer manager state.
  input  wire logic [CW-1:0]    free_blocks,
  input  wire logic             perm_exhausted,
  // Queue requests from input control.
  input  wire logic             qreq_valid,
  input  wire logic [PW-1:0]    qreq_src,
  input  wire logic [PW-1:0]    qreq_dst,
  // Requests to the port MACs.
  output logic                  pause_valid,
  output logic [PW-1:0]         pause_port,
  output logic [15:0]           pause_time,
  output logic [15:0]           pause_ethtype,
  output logic [15:0]           pause_opcode,
  output logic                  jam_valid,
  output logic [PW-1:0]         jam_port,
  output logic                  drop_valid,
  output logic [NPORT-1:0]      fc_on
);

  logic [31:0]      ctrl;
  logic [31:0]      flow_threshold_config;
  logic [NPORT-1:0] speed;
  logic [NPORT-1:0] duplex;
  logic [NPORT-1:0] bp_en;
  logic [CW-1:0]    buf_blocks;
  bfc_state_t       st;
  bfc_state_t       next_st;
  logic [NPORT-1:0] paused;
  logic [CW-1:0]    used;
  logic             over_hi;
  logic             under_lo;
  logic             slow_any;
  logic [31:0]      max_wait;
  logic [15:0]      req_pause;
  logic             wr_en;
  logic             rd_setup;
  logic             addr_ok;
  logic             err_q;
  logic [31:0]      rd_mux;

  // Wait in slot times of a port for a given block count; a fast port
  // waits ten times as many of its own slots when a slow port exists.
  function automatic logic [31:0] wait_slots(input logic [CW-1:0] blk,
                                             input logic fast_vs_slow);
    logic [31:0] s;
    s = 32'(blk) * 32'(SLOTS_PER_BLK);
    if (fast_vs_slow) begin
      s = s * 32'(SPEED_RATIO);
    end
    return s;
  endfunction

  // Half of the congestion wait, clipped to the 16-bit pause field.
  function automatic logic [15:0] pause_of(input logic [31:0] w);
    logic [31:0] h;
    h = w >> 1;
    if (h > 32'(PAUSE_MAX)) begin
      return PAUSE_MAX;
    end
    return h[15:0];
  endfunction

  function automatic logic [PW-1:0] lowest_set(input logic [NPORT-1:0] m);
    logic [PW-1:0] r;
    r = '0;
    for (int i = NPORT - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = PW'(i);
      end
    end
    return r;
  endfunction

  // Shared buffer use in blocks; a free count above size reads as idle.
  assign used     = (free_blocks > buf_blocks) ? '0 : buf_blocks - free_blocks;
  assign over_hi  = used > flow_threshold_config[THR_HI_POS +: 16];
  assign under_lo = used < flow_threshold_config[THR_LO_POS +: 16];
  assign slow_any = ~&speed;
  assign max_wait = wait_slots(buf_blocks, 1'b0);
  // Congestion factor is the wait for blocks in use now.
  assign req_pause = pause_of(wait_slots(used,
                              slow_any & speed[qreq_src]));

  // APB: zero wait states, read data captured in the setup cycle.
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pslverr  = psel & penable & err_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    if (paddr == OFF_CTRL) begin
      rd_mux = ctrl;
    end else if (paddr == OFF_THRESH) begin
      rd_mux = flow_threshold_config;
    end else if (paddr == OFF_SPEED) begin
      rd_mux = {16'h0000, speed};
    end else if (paddr == OFF_DUPLEX) begin
      rd_mux = {16'h0000, duplex};
    end else if (paddr == OFF_BP_EN) begin
      rd_mux = {16'h0000, bp_en};
    end else if (paddr == OFF_BUF_BLK) begin
      rd_mux = {16'h0000, buf_blocks};
    end else if (paddr == OFF_STATUS) begin
      rd_mux = {14'h0000, perm_exhausted, st == ST_CONG, fc_on};
    end else if (paddr == OFF_MAX_WAIT) begin
      rd_mux = max_wait;
    end else if (paddr == OFF_PAUSE) begin
      rd_mux = {16'h0000, pause_of(wait_slots(used, slow_any))};
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      err_q  <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q  <= ~addr_ok;
    end
  end

  // Configuration registers; read-only offsets ignore writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl                  <= RST_CTRL;
      flow_threshold_config <= RST_THRESH;
      speed                 <= RST_SPEED;
      duplex                <= RST_DUPLEX;
      bp_en                 <= RST_BP_EN;
      buf_blocks            <= RST_BUF_BLK;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= {31'h0000_0000, pwdata[CTRL_FC_EN]};
      end else if (paddr == OFF_THRESH) begin
        flow_threshold_config <= pwdata;
      end else if (paddr == OFF_SPEED) begin
        speed <= pwdata[15:0];
      end else if (paddr == OFF_DUPLEX) begin
        duplex <= pwdata[15:0];
      end else if (paddr == OFF_BP_EN) begin
        bp_en <= pwdata[15:0];
      end else if (paddr == OFF_BUF_BLK) begin
        buf_blocks <= pwdata[15:0];
      end
    end
  end

  // Congestion state with hysteresis between the two thresholds.
  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (over_hi && perm_exhausted) begin
          next_st = ST_CONG;
        end
      end
      ST_CONG: begin
        if (under_lo) begin
          next_st = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (paused == '0 || (paused & ~(NPORT'(1) << lowest_set(paused)))
            == '0) begin
          next_st = ST_IDLE;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Every output port is flowed while the switch is congested and at least one block is in use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_on <= '0;
    end else begin
      fc_on <= {NPORT{next_st == ST_CONG && used != '0}};
    end
  end

  // Queue request decisions and resume pauses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_valid <= 1'b0;
      pause_port  <= '0;
      pause_time  <= 16'h0000;
      jam_valid   <= 1'b0;
      jam_port    <= '0;
      drop_valid  <= 1'b0;
      paused      <= '0;
    end else begin
      pause_valid <= 1'b0;
      jam_valid   <= 1'b0;
      drop_valid  <= 1'b0;
      if (st == ST_RESUME) begin
        if (paused != '0) begin
          pause_valid <= 1'b1;
          pause_port  <= lowest_set(paused);
          pause_time  <= PAUSE_ZERO;
          paused[lowest_set(paused)] <= 1'b0;
        end
      end else if (qreq_valid && fc_on[qreq_dst]) begin
        if (duplex[qreq_src]) begin
          if (ctrl[CTRL_FC_EN]) begin
            pause_valid <= 1'b1;
            pause_port  <= qreq_src;
            pause_time  <= req_pause;
            paused[qreq_src] <= 1'b1;
          end else begin
            drop_valid <= free_blocks == '0;
          end
        end else if (bp_en[qreq_src]) begin
          jam_valid <= 1'b1;
          jam_port  <= qreq_src;
        end else begin
          drop_valid <= 1'b1;
        end
      end else if (qreq_valid && free_blocks == '0) begin
        drop_valid <= 1'b1;
      end
    end
  end

  // Fixed MAC control fields travel with every pause request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_ethtype <= 16'h0000;
      pause_opcode  <= 16'h0000;
    end else begin
      pause_ethtype <= CTL_ETHTYPE;
      pause_opcode  <= PAUSE_OPCODE;
    end
  end

  sequence s_flowed_req;
    qreq_valid && fc_on[qreq_dst] && st != ST_RESUME;
  endsequence

  sequence s_full_fc;
    s_flowed_req ##0 duplex[qreq_src] && ctrl[CTRL_FC_EN];
  endsequence

  sequence s_half_req;
    s_flowed_req ##0 !duplex[qreq_src];
  endsequence

  a_pause_source: assert property (@(posedge clk) disable iff (!rst_n)
    s_full_fc |=> pause_valid && pause_port == $past(qreq_src))
    else $error("pause not sent to requesting port");

  a_pause_value: assert property (@(posedge clk) disable iff (!rst_n)
    s_full_fc |=> pause_time == $past(req_pause) && pause_time != 16'h0000
                  || $past(used) == '0)
    else $error("pause time does not follow buffer use");

  a_pause_sat: assert property (@(posedge clk) disable iff (!rst_n)
    s_full_fc ##0 (wait_slots(used, slow_any & speed[qreq_src]) >> 1)
      > 32'h0000_ffff |=> pause_time == 16'hffff)
    else $error("pause time not saturated");

  a_resume_zero: assert property (@(posedge clk) disable iff (!rst_n)
    st == ST_RESUME && paused != '0 |=> pause_valid && pause_time == 16'h0000)
    else $error("resume pause not zero");

  // Flow control is lifted for the whole resume sweep, so a request made
  // while the zero pauses go out is never paused again.
  a_resume_fc_off: assert property (@(posedge clk) disable iff (!rst_n)
    st == ST_RESUME |-> fc_on == '0)
    else $error("flow control left on while resuming");

  a_nofc_drop: assert property (@(posedge clk) disable iff (!rst_n)
    qreq_valid && free_blocks == '0 && !ctrl[CTRL_FC_EN] && st != ST_RESUME
    && duplex[qreq_src] |=> drop_valid && !pause_valid)
    else $error("frame not dropped without buffers");

  a_jam_half: assert property (@(posedge clk) disable iff (!rst_n)
    s_half_req ##0 bp_en[qreq_src]
    |=> jam_valid && jam_port == $past(qreq_src) && !drop_valid)
    else $error("jam not sent on half duplex port");

  a_drop_nobp: assert property (@(posedge clk) disable iff (!rst_n)
    s_half_req ##0 !bp_en[qreq_src] |=> drop_valid && !jam_valid)
    else $error("frame not dropped without backpressure");

  a_cong_enter: assert property (@(posedge clk) disable iff (!rst_n)
    st == ST_IDLE && over_hi && perm_exhausted && used != '0
    |=> st == ST_CONG && fc_on == {NPORT{1'b1}})
    else $error("congestion not entered above threshold");

  a_max_wait: assert property (@(posedge clk) disable iff (!rst_n)
    max_wait == 32'(buf_blocks) * 32'd24)
    else $error("max wait not buffer size in slots");

  a_pause_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    pause_valid |-> pause_opcode == 16'h0001 && pause_ethtype == 16'h8808)
    else $error("pause frame fields wrong");

endmodule

// File: bfc_far_model.sv
// Far-side model: buffer manager, input control and the port MACs.
`timescale 1ns/1ps
module bfc_far_model
  import bfc_pkg::*;
(
  // Clock.
  input  wire logic          clk,
  // Buffer state and queue requests toward the block.
  output logic [CW-1:0]      free_blocks,
  output logic               perm_exhausted,
  output logic               qreq_valid,
  output logic [PW-1:0]      qreq_src,
  output logic [PW-1:0]      qreq_dst,
  // Notifications that the MACs act on.
  input  wire logic          pause_valid,
  input  wire logic          jam_valid,
  input  wire logic          drop_valid
);
  initial begin
    free_blocks = '0;
    perm_exhausted = 1'b0;
    qreq_valid = 1'b0;
    qreq_src = '0;
    qreq_dst = '0;
  end

  // One request; kind is {pause, jam, drop} seen in the answer cycle.
  task automatic req(input logic [PW-1:0] s, input logic [PW-1:0] d,
                     output logic [2:0] kind);
    @(posedge clk);
    qreq_valid <= 1'b1;
    qreq_src <= s;
    qreq_dst <= d;
    @(posedge clk);
    qreq_valid <= 1'b0;
    // Idle lines flip so a stale port number never looks valid.
    qreq_src <= ~s;
    qreq_dst <= ~d;
    #1 kind = {pause_valid, jam_valid, drop_valid};
  endtask

  task automatic set_buf(input logic [CW-1:0] f, input logic p);
    @(posedge clk);
    free_blocks <= f;
    perm_exhausted <= p;
  endtask
endmodule

// File: buffer_flow_control_test.sv
// Self-checking testbench for the buffer flow control block.
`timescale 1ns/1ps
module buffer_flow_control_test;
  import bfc_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic [CW-1:0]     free_blocks;
  logic              perm_exhausted;
  logic              qreq_valid;
  logic [PW-1:0]     qreq_src;
  logic [PW-1:0]     qreq_dst;
  logic              pause_valid;
  logic [PW-1:0]     pause_port;
  logic [15:0]       pause_time;
  logic [15:0]       pause_ethtype;
  logic [15:0]       pause_opcode;
  logic              jam_valid;
  logic [PW-1:0]     jam_port;
  logic              drop_valid;
  logic [NPORT-1:0]  fc_on;
  int                errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  logic [31:0]       rd;
  logic              er;
  logic [2:0]        kind;

  always #5 clk = ~clk;

  bfc_flow_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .free_blocks(free_blocks), .perm_exhausted(perm_exhausted),
    .qreq_valid(qreq_valid), .qreq_src(qreq_src), .qreq_dst(qreq_dst),
    .pause_valid(pause_valid), .pause_port(pause_port),
    .pause_time(pause_time), .pause_ethtype(pause_ethtype),
    .pause_opcode(pause_opcode), .jam_valid(jam_valid),
    .jam_port(jam_port), .drop_valid(drop_valid), .fc_on(fc_on));

  bfc_far_model far (.clk(clk), .free_blocks(free_blocks),
    .perm_exhausted(perm_exhausted), .qreq_valid(qreq_valid),
    .qreq_src(qreq_src), .qreq_dst(qreq_dst), .pause_valid(pause_valid),
    .jam_valid(jam_valid), .drop_valid(drop_valid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // Read data and error are taken at the edge where pready is sampled.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic restart();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Buffer of blk blocks, thresholds 50 over and 10 under.
  task automatic setup(input logic [31:0] dup, input logic [31:0] bp,
                       input logic [31:0] spd, input logic [31:0] blk);
    restart();
    apb(1'b1, OFF_DUPLEX, dup);
    apb(1'b1, OFF_BP_EN, bp);
    apb(1'b1, OFF_SPEED, spd);
    apb(1'b1, OFF_BUF_BLK, blk);
    apb(1'b1, OFF_THRESH, 32'h0032_000a);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
  endtask

  task automatic wait_fc();
    int n;
    for (n = 0; n < 20 && fc_on !== 16'hffff; n++)
      @(posedge clk);
    chk(32'(fc_on), 32'h0000_ffff);
  endtask

  task automatic t_regs();
    apb(1'b0, OFF_CTRL, '0);
    chk(rd, RST_CTRL);
    apb(1'b0, OFF_THRESH, '0);
    chk(rd, RST_THRESH);
    apb(1'b0, OFF_SPEED, '0);
    chk(rd, {16'h0000, RST_SPEED});
    apb(1'b0, OFF_DUPLEX, '0);
    chk(rd, {16'h0000, RST_DUPLEX});
    apb(1'b0, OFF_BP_EN, '0);
    chk(rd, {16'h0000, RST_BP_EN});
    apb(1'b0, OFF_BUF_BLK, '0);
    chk(rd, {16'h0000, RST_BUF_BLK});
    apb(1'b1, OFF_THRESH, 32'h1234_0abc);
    apb(1'b0, OFF_THRESH, '0);
    chk(rd, 32'h1234_0abc);
    apb(1'b1, OFF_MAX_WAIT, 32'h0000_5555);
    apb(1'b0, OFF_MAX_WAIT, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h40, '0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_drop_nofc();
    restart();
    apb(1'b1, OFF_BUF_BLK, 32'd100);
    far.set_buf(16'h0000, 1'b1);
    far.req(4'h2, 4'h7, kind);
    chk(32'(kind), 32'h0000_0001);
    $display("test drop without flow control done");
  endtask

  task automatic t_pause();
    int n;
    setup(32'h0000_ffff, 32'h0, 32'h0000_ffff, 32'd100);
    far.set_buf(16'd20, 1'b1);
    wait_fc();
    far.req(4'h3, 4'h5, kind);
    chk(32'(kind), 32'h0000_0004);
    chk(32'(pause_port), 32'h3);
    chk(32'(pause_time), 32'd960);
    chk({pause_ethtype, pause_opcode}, 32'h8808_0001);
    apb(1'b0, OFF_MAX_WAIT, '0);
    chk(rd, 32'd2400);
    apb(1'b0, OFF_STATUS, '0);
    chk(rd, 32'h0003_ffff);
    apb(1'b0, OFF_PAUSE, '0);
    chk(rd, 32'd960);
    far.set_buf(16'd95, 1'b1);
    for (n = 0; n < 20 && pause_valid !== 1'b1; n++)
      @(posedge clk);
    chk(32'(pause_valid), 32'h0000_0001);
    chk(32'({pause_port, pause_time}), 32'h0003_0000);
    $display("test pause and resume done");
  endtask

  task automatic t_sat();
    setup(32'h0000_ffff, 32'h0, 32'h0000_fffe, 32'h2000);
    far.set_buf(16'h1f9c, 1'b1);
    wait_fc();
    far.req(4'h1, 4'h2, kind);
    chk(32'(pause_time), 32'h0000_2ee0);
    apb(1'b0, OFF_PAUSE, '0);
    chk(rd, 32'h0000_2ee0);
    far.set_buf(16'h0000, 1'b1);
    repeat (2) @(posedge clk);
    far.req(4'h1, 4'h2, kind);
    chk(32'(pause_time), 32'h0000_ffff);
    $display("test pause time scaling done");
  endtask

  task automatic t_half();
    setup(32'h0, 32'h0000_0010, 32'h0000_ffff, 32'd100);
    far.set_buf(16'd20, 1'b1);
    wait_fc();
    far.req(4'h4, 4'h5, kind);
    chk(32'(kind), 32'h0000_0002);
    chk(32'(jam_port), 32'h4);
    far.req(4'h6, 4'h5, kind);
    chk(32'(kind), 32'h0000_0001);
    $display("test half duplex done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_drop_nofc();
    t_pause();
    t_sat();
    t_half();
    report_and_stop();
  end
endmodule
